// ---- rtl/cio_framer.sv ----
// Purpose: builds cyclic input assembly payloads sent target to originator
// Assumes: open request and instance come from the network stack
// Notes: status is snapshotted at the start of each frame
//
// What this block does
// - drive acts as target, only answering open requests
// - input data produced at a preset period, not on request
// - exchange uses a class 1 connection
// - target to originator frames flagged multicast
// - cyclic trigger, one connection, connection tags refused
// - scheduled priority; configuration data refused at open
// - drive status sent periodically as input instance data
// - instance 70: speed in rpm, bytes 2 low and 3 high
// - instance 110: speed in hz, bytes 2 low and 3 high
`timescale 1ns/1ps
module cio_framer #(
  parameter int PERIOD_CYC = cio_pkg::PERIOD_CYC_DEF
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  // connection requests from originator
  input wire logic OPEN_REQ_I,
  input wire logic CLOSE_REQ_I,
  input wire logic [7:0] OPEN_INST_I,
  input wire logic OPEN_CLASS1_I,
  input wire logic OPEN_HAS_CFG_I,
  input wire logic OPEN_HAS_TAG_I,
  output logic OPEN_ACK_O,
  output logic OPEN_NAK_O,
  output logic CONN_ACTIVE_O,
  // drive status
  input wire cio_pkg::cio_status_s STATUS_I,
  // payload byte stream
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  output logic [7:0] TX_DATA_O,
  output logic TX_FIRST_O,
  output logic TX_LAST_O,
  output logic TX_MCAST_O,
  output logic TX_SCHED_O
);
  // refuse a period too short for the timer to wrap
  if (PERIOD_CYC < 2) begin : g_bad_period
    $error("PERIOD_CYC must be at least 2");
  end

  cio_pkg::cio_conn_e conn_q;
  cio_pkg::cio_tx_e tx_q;
  logic [7:0] inst_q;
  logic [31:0] per_q;
  logic [3:0] idx_q;
  logic [3:0] len_q;
  cio_pkg::cio_status_s snap_q;
  logic ack_q, nak_q;
  logic inst_ok, open_ok, tick, beat;

  function automatic logic [3:0] inst_len(input logic [7:0] inst);
    case (inst)
      cio_pkg::INST_PARAM1: inst_len = cio_pkg::LEN_PARAM1;
      cio_pkg::INST_PARAM2: inst_len = cio_pkg::LEN_PARAM2;
      default: inst_len = cio_pkg::LEN_SPEED;
    endcase
  endfunction

  // legal instance check
  assign inst_ok = (OPEN_INST_I == cio_pkg::INST_BASIC_RPM) ||
    (OPEN_INST_I == cio_pkg::INST_EXT_RPM) || (OPEN_INST_I == cio_pkg::INST_BASIC_HZ) ||
    (OPEN_INST_I == cio_pkg::INST_EXT_HZ) || (OPEN_INST_I == cio_pkg::INST_PARAM1) ||
    (OPEN_INST_I == cio_pkg::INST_PARAM2);
  // accept only class 1, no config, no tag, while idle
  assign open_ok = inst_ok && OPEN_CLASS1_I && !OPEN_HAS_CFG_I && !OPEN_HAS_TAG_I &&
    (conn_q == cio_pkg::CONN_IDLE);

  // connection state, opened only on request
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      conn_q <= cio_pkg::CONN_IDLE;
      inst_q <= 8'h00;
    end else begin
      case (conn_q)
        cio_pkg::CONN_IDLE: begin
          if (OPEN_REQ_I && open_ok) begin
            conn_q <= cio_pkg::CONN_OPEN;
            inst_q <= OPEN_INST_I;
          end
        end
        cio_pkg::CONN_OPEN: begin
          if (CLOSE_REQ_I) begin
            conn_q <= cio_pkg::CONN_IDLE;
          end
        end
        default: conn_q <= cio_pkg::CONN_IDLE;
      endcase
    end
  end

  // open answers, one-cycle pulses
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      ack_q <= 1'b0;
      nak_q <= 1'b0;
    end else begin
      ack_q <= OPEN_REQ_I && open_ok;
      nak_q <= OPEN_REQ_I && !open_ok; // a second connection is refused
    end
  end

  // production period timer
  assign tick = (conn_q == cio_pkg::CONN_OPEN) && (per_q == 32'(PERIOD_CYC - 1));
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I || conn_q != cio_pkg::CONN_OPEN) begin
      per_q <= 32'h0000_0000;
    end else if (tick) begin
      per_q <= 32'h0000_0000;
    end else begin
      per_q <= per_q + 32'h0000_0001;
    end
  end

  // frame sequencer with snapshot
  assign beat = TX_VALID_O && TX_READY_I;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      tx_q <= cio_pkg::TX_WAIT;
      idx_q <= 4'h0;
      len_q <= 4'h0;
      snap_q <= '0;
    end else begin
      case (tx_q)
        cio_pkg::TX_WAIT: begin
          if (tick) begin
            tx_q <= cio_pkg::TX_SEND;
            idx_q <= 4'h0;
            len_q <= inst_len(inst_q);
            snap_q <= STATUS_I;
          end
        end
        cio_pkg::TX_SEND: begin
          if (conn_q != cio_pkg::CONN_OPEN) begin
            tx_q <= cio_pkg::TX_WAIT;
          end else if (beat) begin
            if (idx_q == len_q - 4'h1) begin
              tx_q <= cio_pkg::TX_WAIT;
            end
            idx_q <= idx_q + 4'h1;
          end
        end
        default: tx_q <= cio_pkg::TX_WAIT;
      endcase
    end
  end

  // byte selection per assembly layout
  logic [7:0] flags_basic, flags_ext, byte_d;
  // byte 0 flags placed by the shared bit positions
  always_comb begin
    flags_basic = 8'h00;
    flags_basic[cio_pkg::BIT_FAULT] = snap_q.fault;
    flags_basic[cio_pkg::BIT_FWD] = snap_q.forward_running_flag;
    flags_ext = flags_basic;
    flags_ext[cio_pkg::BIT_WARN] = snap_q.warning;
    flags_ext[cio_pkg::BIT_REV] = snap_q.reverse_running;
    flags_ext[cio_pkg::BIT_READY] = snap_q.ready;
    flags_ext[cio_pkg::BIT_CTRL_NET] = snap_q.ctrl_from_net;
    flags_ext[cio_pkg::BIT_REF_NET] = snap_q.ref_from_net;
    flags_ext[cio_pkg::BIT_AT_REF] = snap_q.at_reference;
  end
  always_comb begin
    logic ext, hz;
    logic [15:0] spd;
    ext = (inst_q == cio_pkg::INST_EXT_RPM) || (inst_q == cio_pkg::INST_EXT_HZ);
    hz = (inst_q == cio_pkg::INST_BASIC_HZ) || (inst_q == cio_pkg::INST_EXT_HZ);
    spd = hz ? snap_q.speed_hz : snap_q.speed_rpm;
    byte_d = 8'h00;
    if (inst_q == cio_pkg::INST_PARAM1 || inst_q == cio_pkg::INST_PARAM2) begin
      case (idx_q)
        4'h0: byte_d = snap_q.param1[7:0];
        4'h1: byte_d = snap_q.param1[15:8];
        4'h2: byte_d = snap_q.param2[7:0];
        4'h3: byte_d = snap_q.param2[15:8];
        default: byte_d = 8'h00;
      endcase
    end else begin
      case (idx_q)
        4'h0: byte_d = ext ? flags_ext : flags_basic;
        4'h1: byte_d = ext ? snap_q.drive_state : 8'h00;
        4'h2: byte_d = spd[7:0];
        4'h3: byte_d = spd[15:8];
        default: byte_d = 8'h00;
      endcase
    end
  end

  // registered data output
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      TX_DATA_O <= 8'h00;
    end else begin
      TX_DATA_O <= byte_d;
    end
  end

  logic sending_q;
  // frame in progress, dropped once the last byte is taken
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      sending_q <= 1'b0;
    end else begin
      sending_q <= (tx_q == cio_pkg::TX_SEND) && (conn_q == cio_pkg::CONN_OPEN) &&
        !(beat && idx_q == len_q - 4'h1);
    end
  end

  // stream handshake; valid waits out the register stage so data and valid arrive together
  logic [3:0] oidx_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      oidx_q <= 4'h0;
    end else begin
      oidx_q <= idx_q;
    end
  end
  assign TX_VALID_O = sending_q && (oidx_q == idx_q) && (conn_q == cio_pkg::CONN_OPEN);
  assign TX_FIRST_O = TX_VALID_O && (idx_q == 4'h0);
  assign TX_LAST_O = TX_VALID_O && (idx_q == len_q - 4'h1);
  assign TX_MCAST_O = TX_VALID_O;
  assign TX_SCHED_O = TX_VALID_O;
  assign OPEN_ACK_O = ack_q;
  assign OPEN_NAK_O = nak_q;
  assign CONN_ACTIVE_O = (conn_q == cio_pkg::CONN_OPEN);

  // production steps: tick taken while idle and kept open, then first byte shown
  sequence s_tick_taken;
    tick && (tx_q == cio_pkg::TX_WAIT) ##1 CONN_ACTIVE_O && !CLOSE_REQ_I;
  endsequence
  sequence s_first_shown;
    ##1 TX_FIRST_O;
  endsequence

  // open answers, stream markings and payload layout
  a_no_self_open: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    $rose(CONN_ACTIVE_O) |-> $past(OPEN_REQ_I))
    else $error("connection opened unasked");
  a_cfg_refused: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    OPEN_REQ_I && (OPEN_HAS_CFG_I || OPEN_HAS_TAG_I) |=> OPEN_NAK_O && !OPEN_ACK_O)
    else $error("config or tag open accepted");
  a_class_one: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    OPEN_REQ_I && !OPEN_CLASS1_I |=> !OPEN_ACK_O)
    else $error("non class 1 accepted");
  a_mcast_out: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    TX_VALID_O |-> TX_MCAST_O && TX_SCHED_O)
    else $error("frame not multicast");
  a_cyclic_tick: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    s_tick_taken |-> s_first_shown)
    else $error("production missed");
  a_rpm_low: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    TX_VALID_O && inst_q == cio_pkg::INST_BASIC_RPM && idx_q == 4'h2
    |-> TX_DATA_O == snap_q.speed_rpm[7:0])
    else $error("rpm low byte wrong");
  a_hz_high: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    TX_VALID_O && inst_q == cio_pkg::INST_BASIC_HZ && idx_q == 4'h3
    |-> TX_DATA_O == snap_q.speed_hz[15:8])
    else $error("hz high byte wrong");
  a_basic_flags: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    TX_FIRST_O && inst_q == cio_pkg::INST_BASIC_RPM
    |-> TX_DATA_O == {5'h00, snap_q.forward_running_flag, 1'b0, snap_q.fault})
    else $error("basic flags wrong");
  a_param_first: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    TX_FIRST_O && inst_q == cio_pkg::INST_PARAM1 |-> TX_DATA_O == snap_q.param1[7:0])
    else $error("param low byte wrong");
endmodule // cio_framer

// ---- common/cio_pkg.sv ----
// Purpose: shared constants and types for the cyclic input assembly framer
// Assumes: byte-wide payload stream, one connection at a time
// Notes: instance numbers select the payload layout
package cio_pkg;
  // input assembly instance numbers
  localparam logic [7:0] INST_BASIC_RPM = 8'h46; // 70
  localparam logic [7:0] INST_EXT_RPM = 8'h47; // 71
  localparam logic [7:0] INST_BASIC_HZ = 8'h6E; // 110
  localparam logic [7:0] INST_EXT_HZ = 8'h6F; // 111
  localparam logic [7:0] INST_PARAM1 = 8'h8D; // 141
  localparam logic [7:0] INST_PARAM2 = 8'h8E; // 142
  // payload lengths in bytes
  localparam logic [3:0] LEN_SPEED = 4'h4;
  localparam logic [3:0] LEN_PARAM1 = 4'h2;
  localparam logic [3:0] LEN_PARAM2 = 4'h4;
  // byte 0 flag positions
  localparam int BIT_FAULT = 0;
  localparam int BIT_WARN = 1;
  localparam int BIT_FWD = 2;
  localparam int BIT_REV = 3;
  localparam int BIT_READY = 4;
  localparam int BIT_CTRL_NET = 5;
  localparam int BIT_REF_NET = 6;
  localparam int BIT_AT_REF = 7;
  // default production period in cycles
  localparam int PERIOD_CYC_DEF = 1000;

  // drive status carried into the framer
  typedef struct packed {
    logic fault;
    logic warning;
    logic forward_running_flag;
    logic reverse_running;
    logic ready;
    logic ctrl_from_net;
    logic ref_from_net;
    logic at_reference;
    logic [7:0] drive_state;
    logic [15:0] speed_rpm;
    logic [15:0] speed_hz;
    logic [15:0] param1;
    logic [15:0] param2;
  } cio_status_s;

  typedef enum logic [1:0] {CONN_IDLE, CONN_OPEN} cio_conn_e;
  typedef enum logic [1:0] {TX_WAIT, TX_SEND} cio_tx_e;
endpackage

// ---- verif/cio_orig_model.sv ----
// Purpose: originator side stream sink for the cyclic input framer
// Assumes: one byte taken per edge with valid and ready both high
// Notes: stores {last, first, data} of every byte and frame start cycles
`timescale 1ns/1ps
module cio_orig_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // stream from framer
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic first_i,
  input wire logic last_i,
  input wire logic mcast_i,
  input wire logic sched_i,
  // stall control and ready back
  input wire logic stall_i,
  output logic ready_o
);
  logic [9:0] rx_q[$];
  int start_t[$];
  int bad_marks = 0;
  int cyc = 0;
  int seed = 32'h9d0241af;
  logic first_q = 1'b0;
  // ready moves after the falling edge, random stalls when asked
  always @(negedge clk_i) begin
    ready_o <= rst_n_i && (!stall_i || $random(seed) % 2 == 0);
  end
  // take bytes on the rising edge only, cyclic data with no request
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    first_q <= valid_i && first_i;
    // frame start is where its first byte is first shown, stalls aside
    if (valid_i && first_i && !first_q) start_t.push_back(cyc);
    if (valid_i && ready_o) begin
      if (mcast_i !== 1'b1 || sched_i !== 1'b1) bad_marks++;
      rx_q.push_back({last_i, first_i, data_i});
    end
  end
endmodule // cio_orig_model

// ---- verif/cyclic_io_status_assembly_tb.sv ----
// Purpose: self-checking bench for the cyclic input assembly framer
// Assumes: short production period set through the parameter
// Notes: expected payloads come from an integer model of each layout
`timescale 1ns/1ps
module cyclic_io_status_assembly_tb;
  localparam int P = 16;
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, cls = 1'b0, c1 = 1'b0, cfg = 1'b0, tag = 1'b0;
  logic [7:0] inst = 8'h00;
  logic ack, nak, act, vld, rdy, frst, lst, mc, sch, stall = 1'b0;
  logic [7:0] dat;
  cio_pkg::cio_status_s st = '0;
  logic [7:0] tab [6] = '{cio_pkg::INST_BASIC_RPM, cio_pkg::INST_EXT_RPM,
    cio_pkg::INST_BASIC_HZ, cio_pkg::INST_EXT_HZ, cio_pkg::INST_PARAM1, cio_pkg::INST_PARAM2};
  logic [9:0] exp_q[$];
  int n_errors = 0, check_count = 0, seed = 32'h9d0241af, d = 0;
  // clock of 4 ns
  always #2 clk = ~clk;
  cio_framer #(.PERIOD_CYC(P)) DUT (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .OPEN_REQ_I(req),
    .CLOSE_REQ_I(cls), .OPEN_INST_I(inst), .OPEN_CLASS1_I(c1), .OPEN_HAS_CFG_I(cfg),
    .OPEN_HAS_TAG_I(tag), .OPEN_ACK_O(ack), .OPEN_NAK_O(nak), .CONN_ACTIVE_O(act),
    .STATUS_I(st), .TX_VALID_O(vld), .TX_READY_I(rdy), .TX_DATA_O(dat), .TX_FIRST_O(frst),
    .TX_LAST_O(lst), .TX_MCAST_O(mc), .TX_SCHED_O(sch));
  cio_orig_model u_orig (.clk_i(clk), .rst_n_i(rst_n), .valid_i(vld), .data_i(dat),
    .first_i(frst), .last_i(lst), .mcast_i(mc), .sched_i(sch), .stall_i(stall), .ready_o(rdy));
  // compare and count
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // originator open request, one cycle pulse, answer one cycle later
  task open(input logic [7:0] i, input logic k1, input logic kc, input logic kt, input logic ok);
    @(negedge clk);
    inst = i;
    c1 = k1;
    cfg = kc;
    tag = kt;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    check("ack", ack, ok);
    check("nak", nak, !ok);
  endtask
  // integer model of each input layout
  task build(input logic [7:0] i, input cio_pkg::cio_status_s s);
    int b[$], f, sp;
    logic [79:0] v;
    v = s;
    f = 0;
    for (int n = 0; n < 8; n++) f += v[79-n] << n;
    sp = (i == cio_pkg::INST_BASIC_HZ || i == cio_pkg::INST_EXT_HZ) ? s.speed_hz : s.speed_rpm;
    case (i)
      cio_pkg::INST_BASIC_RPM: b = {f & 5, 0, sp % 256, sp / 256};
      cio_pkg::INST_EXT_RPM: b = {f, s.drive_state, sp % 256, sp / 256};
      cio_pkg::INST_BASIC_HZ: b = {f & 5, 0, sp % 256, sp / 256};
      cio_pkg::INST_EXT_HZ: b = {f, s.drive_state, sp % 256, sp / 256};
      cio_pkg::INST_PARAM1: b = {s.param1 % 256, s.param1 / 256};
      default: b = {s.param1 % 256, s.param1 / 256, s.param2 % 256, s.param2 / 256};
    endcase
    exp_q.delete();
    foreach (b[n]) exp_q.push_back({n == b.size() - 1, n == 0, b[n][7:0]});
  endtask
  // watchdog, well past twelve connections of at most 810 cycles each
  initial begin
    #60000;
    n_errors++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    open(8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    open(cio_pkg::INST_EXT_HZ, 1'b0, 1'b0, 1'b0, 1'b0);
    open(cio_pkg::INST_EXT_HZ, 1'b1, 1'b1, 1'b0, 1'b0);
    open(cio_pkg::INST_EXT_HZ, 1'b1, 1'b0, 1'b1, 1'b0);
    check("idle", act, 1'b0);
    for (int k = 0; k < 12; k++) begin
      st = 80'({$random(seed), $random(seed), $random(seed)});
      stall = (k >= 6);
      build(tab[k % 6], st);
      u_orig.rx_q.delete();
      u_orig.start_t.delete();
      open(tab[k % 6], 1'b1, 1'b0, 1'b0, 1'b1);
      check("active", act, 1'b1);
      open(tab[(k + 1) % 6], 1'b1, 1'b0, 1'b0, 1'b0);
      for (int w = 0; w < 800 && u_orig.start_t.size() < 3; w++) @(negedge clk);
      check("frames", u_orig.start_t.size() >= 3, 1'b1);
      for (int j = 0; j < 2 * exp_q.size(); j++) begin
        check("byte", u_orig.rx_q[j], exp_q[j % exp_q.size()]);
      end
      d = u_orig.start_t[1] - u_orig.start_t[0];
      check("period", stall ? d % P : d, stall ? 0 : P);
      check("marks", u_orig.bad_marks, 0);
      @(negedge clk);
      cls = 1'b1;
      @(negedge clk);
      cls = 1'b0;
      check("closed", act, 1'b0);
      check("abort", vld, 1'b0);
      repeat (4) @(negedge clk);
      check("quiet", vld, 1'b0);
    end
    finish_test();
  end
endmodule // cyclic_io_status_assembly_tb
